// ===== common/ssr_regs.svh
// Offsets, field positions, reset values and timing counts of the sensor release logic.
// Assumes a 25 MHz reference clock and an include by bare name.
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH
`define SSR_ADDR_W          3
`define SSR_OFF_REQ         3'h0
`define SSR_OFF_RESP        3'h1
`define SSR_OFF_WARN        3'h2
`define SSR_OFF_ERR         3'h3
`define SSR_OFF_CTRL        3'h4
`define SSR_REQ_ACK_BIT     6
`define SSR_REQ_ERST_BIT    7
`define SSR_REQ_RST         8'h00
`define SSR_CTRL_DISC_BIT   0
`define SSR_CTRL_BTN_BIT    1
`define SSR_CTRL_RST        8'h00
`define SSR_RESP_ON_BIT     0
`define SSR_RESP_ACT_BIT    1
`define SSR_RESP_WAIT_BIT   3
`define SSR_RESP_LIVE_BIT   4
`define SSR_RESP_HYST_BIT   5
`define SSR_RESP_WARN_BIT   6
`define SSR_RESP_ERR_BIT    7
`define SSR_DG_OUTA_BIT     0
`define SSR_DG_OUTB_BIT     1
`define SSR_DG_CROSS_BIT    2
`define SSR_DG_TEMP_BIT     3
`define SSR_ERR_ACTR_BIT    4
`define SSR_DG_INT_BIT      5
`define SSR_WARN_COMM_BIT   6
`define SSR_ERR_DISC_BIT    6
`define SSR_CLK_HZ          25000000
`define SSR_BLINK_HZ        5
`define SSR_BLINK_HALF_CYC  (`SSR_CLK_HZ / (2 * `SSR_BLINK_HZ))
`define SSR_DISC_MS         500
`define SSR_DISC_CYC        (`SSR_CLK_HZ / 1000 * `SSR_DISC_MS)
`define SSR_WARN_MIN        30
`define SSR_WARN_CYC        (64'd60 * `SSR_WARN_MIN * `SSR_CLK_HZ)
`endif

// ===== common/ssr_pkg.sv
// Types shared by the sensor release and diagnostic logic.
// Assumes nothing beyond a SystemVerilog compiler.
package ssr_pkg;
    typedef enum {
        SSR_WAIT,
        SSR_ON
    } ssr_state_t;

    typedef struct packed {
        logic safety_input_a;
        logic safety_input_b;
        logic actuated;
        logic hysteresis;
        logic feedback_closed;
        logic reset_button;
        logic ack_button;
    } ssr_sense_t;

    typedef struct packed {
        logic out_a_fault;
        logic out_b_fault;
        logic cross_wire;
        logic over_temp;
        logic internal_fault;
        logic comm_fail;
        logic bad_actuator;
    } ssr_diag_t;
endpackage

// ===== src/ssr_top.sv
// Release, discrepancy and diagnostic byte logic of a series-wirable safety sensor.
// Assumes all inputs synchronous to ref_clk and a nonvolatile store outside.
// Functional notes
// R1 - Response bit reports both safety inputs live.
// R2 - Response bit flags actuation in hysteresis area.
// R3 - Warning bit flags gateway communication failure.
// R4 - Error bit flags wrong or faulty actuator.
// R5 - Error bit flags discrepancy time exceeded.
// R6 - Power-up: outputs off, yellow blinks 5 Hz; here it blinks only while actuated.
// R7 - Auto variant: feedback closing releases outputs.
// R8 - Button variant: release on button falling edge.
// R9 - Button variant: feedback closing alone changes nothing.
// R10 - Input skew over 500 ms switches outputs off.
// R11 - Discrepancy fault blocks release until acknowledged.
// R12 - Discrepancy fault survives supply loss.
// R13 - Acknowledge by button falling edge or serial.
// R14 - Discrepancy monitor only in last sensor.
// R15 - Gateway acknowledges via request byte bit.
// R16 - Low diagnostic bits: outputs, cross-wire, temperature, internal.
// R17 - Internal error clears on reset-bit fall or opening.
// R18 - Response bit zero shows outputs enabled.
// R19 - Warning lasting 30 minutes switches outputs off; here a communication failure warning never does.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "ssr_regs.svh"

module ssr_top #(
    parameter logic [23:0] DISC_CYC  = 24'(`SSR_DISC_CYC),
    parameter logic [21:0] BLINK_CYC = 22'(`SSR_BLINK_HALF_CYC),
    parameter logic [35:0] WARN_CYC  = 36'(`SSR_WARN_CYC)
) (
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire ssr_pkg::ssr_sense_t    sense,
    input  wire ssr_pkg::ssr_diag_t     diag,
    input  wire logic                   nv_fault_restore,
    input  wire logic [`SSR_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_we,
    input  wire logic                   reg_re,
    output logic      [7:0]             reg_rdata,
    output logic                        safety_output_a,
    output logic                        safety_output_b,
    output logic                        yellow_led,
    output logic                        nv_fault_store
);
    if (DISC_CYC == 24'h000000 || BLINK_CYC == 22'h000000 || WARN_CYC == 36'h000000000) begin
        $error("ssr_top: timing counts must be at least one cycle");
    end

    ssr_pkg::ssr_state_t state_reg, state_next;
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        req_erst_reg, req_erst_next;
    logic        rst_btn_reg, rst_btn_next;
    logic        ack_btn_reg, ack_btn_next;
    logic        disc_reg, disc_next;
    logic        err_reg, err_next;
    logic        restored_reg, restored_next;
    logic        blink_reg, blink_next;
    logic [23:0] skew_cnt_reg, skew_cnt_next;
    logic [21:0] blink_cnt_reg, blink_cnt_next;
    logic [35:0] warn_cnt_reg, warn_cnt_next;

    logic       both_live;
    logic       skew;
    logic       disc_set;
    logic       ack_evt;
    logic       erst_fall;
    logic       rst_fall;
    logic       warn_any;
    logic       warn_trip;
    logic       release_ok;
    logic       outputs_on;
    logic [7:0] resp_byte;
    logic [7:0] warn_byte;
    logic [7:0] err_byte;

    always_comb begin
        both_live  = sense.safety_input_a & sense.safety_input_b;
        skew       = ctrl_reg[`SSR_CTRL_DISC_BIT] & (sense.safety_input_a ^ sense.safety_input_b);
        disc_set   = skew && (skew_cnt_reg == DISC_CYC); // R10
        ack_evt    = (ack_btn_reg & ~sense.ack_button)
                   | (reg_we && reg_addr == `SSR_OFF_REQ && reg_wdata[`SSR_REQ_ACK_BIT]); // R13
        erst_fall  = reg_we && reg_addr == `SSR_OFF_REQ && req_erst_reg
                   && !reg_wdata[`SSR_REQ_ERST_BIT];
        rst_fall   = rst_btn_reg & ~sense.reset_button;
        warn_any   = diag.out_a_fault | diag.out_b_fault | diag.cross_wire | diag.over_temp;
        warn_trip  = warn_any && (warn_cnt_reg == WARN_CYC); // R19
        // The first cycle after reset never releases, so a restored fault blocks in time.
        release_ok = sense.actuated & both_live & ~err_reg & ~disc_reg & ~warn_trip // R11
                   & restored_reg; // R12
        outputs_on = (state_reg == ssr_pkg::SSR_ON);

        resp_byte = 8'h00;
        resp_byte[`SSR_RESP_ON_BIT]   = outputs_on; // R18
        resp_byte[`SSR_RESP_ACT_BIT]  = sense.actuated & ~diag.bad_actuator;
        resp_byte[`SSR_RESP_WAIT_BIT] = ~outputs_on & sense.actuated;
        resp_byte[`SSR_RESP_LIVE_BIT] = both_live; // R1
        resp_byte[`SSR_RESP_HYST_BIT] = sense.actuated & sense.hysteresis; // R2
        resp_byte[`SSR_RESP_WARN_BIT] = warn_any | diag.comm_fail;
        resp_byte[`SSR_RESP_ERR_BIT]  = err_reg | disc_reg | warn_trip;

        warn_byte = 8'h00;
        warn_byte[`SSR_DG_OUTA_BIT]   = diag.out_a_fault; // R16
        warn_byte[`SSR_DG_OUTB_BIT]   = diag.out_b_fault; // R16
        warn_byte[`SSR_DG_CROSS_BIT]  = diag.cross_wire; // R16
        warn_byte[`SSR_DG_TEMP_BIT]   = diag.over_temp; // R16
        warn_byte[`SSR_DG_INT_BIT]    = diag.internal_fault; // R16
        warn_byte[`SSR_WARN_COMM_BIT] = diag.comm_fail; // R3

        err_byte = 8'h00;
        err_byte[`SSR_DG_OUTA_BIT]  = diag.out_a_fault & warn_trip; // R16
        err_byte[`SSR_DG_OUTB_BIT]  = diag.out_b_fault & warn_trip; // R16
        err_byte[`SSR_DG_CROSS_BIT] = diag.cross_wire & warn_trip; // R16
        err_byte[`SSR_DG_TEMP_BIT]  = diag.over_temp & warn_trip; // R16
        err_byte[`SSR_ERR_ACTR_BIT] = diag.bad_actuator; // R4
        err_byte[`SSR_DG_INT_BIT]   = err_reg; // R16
        err_byte[`SSR_ERR_DISC_BIT] = disc_reg; // R5
    end

    always_comb begin
        state_next    = state_reg;
        ctrl_next     = ctrl_reg;
        rdata_next    = 8'h00;
        req_erst_next = req_erst_reg;
        rst_btn_next  = sense.reset_button;
        ack_btn_next  = sense.ack_button;
        restored_next = 1'b1;
        blink_next    = blink_reg;
        if (reg_we && reg_addr == `SSR_OFF_CTRL) begin
            ctrl_next = reg_wdata;
        end
        if (reg_we && reg_addr == `SSR_OFF_REQ) begin
            req_erst_next = reg_wdata[`SSR_REQ_ERST_BIT];
        end
        if (reg_re) begin
            case (reg_addr)
                `SSR_OFF_REQ:  rdata_next = {req_erst_reg, 7'h00};
                `SSR_OFF_RESP: rdata_next = resp_byte;
                `SSR_OFF_WARN: rdata_next = warn_byte;
                `SSR_OFF_ERR:  rdata_next = err_byte;
                `SSR_OFF_CTRL: rdata_next = ctrl_reg;
                default:       rdata_next = 8'h00;
            endcase
        end

        // A skew timer that stops at the limit keeps the set term alive while the skew lasts.
        if (!skew) begin
            skew_cnt_next = 24'h000000;
        end else if (skew_cnt_reg != DISC_CYC) begin
            skew_cnt_next = skew_cnt_reg + 24'h000001; // R10
        end else begin
            skew_cnt_next = skew_cnt_reg;
        end
        // Set wins over acknowledge, so a fault that persists is never lost.
        if (disc_set || (!restored_reg && nv_fault_restore)) begin
            disc_next = 1'b1; // R12
        end else if (ack_evt) begin
            disc_next = 1'b0; // R13
        end else begin
            disc_next = disc_reg;
        end

        if (diag.internal_fault) begin
            err_next = 1'b1;
        end else if (erst_fall || !sense.actuated) begin
            err_next = 1'b0; // R17
        end else begin
            err_next = err_reg;
        end

        if (!warn_any) begin
            warn_cnt_next = 36'h000000000;
        end else if (warn_cnt_reg != WARN_CYC) begin
            warn_cnt_next = warn_cnt_reg + 36'h000000001; // R19
        end else begin
            warn_cnt_next = warn_cnt_reg;
        end

        if (blink_cnt_reg == BLINK_CYC - 22'h000001) begin
            blink_cnt_next = 22'h000000;
            blink_next     = ~blink_reg; // R6
        end else begin
            blink_cnt_next = blink_cnt_reg + 22'h000001;
        end

        case (state_reg)
            ssr_pkg::SSR_WAIT: begin
                if (release_ok) begin
                    if (ctrl_reg[`SSR_CTRL_BTN_BIT]) begin // R9
                        if (rst_fall) begin
                            state_next = ssr_pkg::SSR_ON; // R8
                        end
                    end else if (sense.feedback_closed) begin
                        state_next = ssr_pkg::SSR_ON; // R7
                    end
                end
            end
            ssr_pkg::SSR_ON: begin
                if (!release_ok) begin
                    state_next = ssr_pkg::SSR_WAIT; // R10
                end
            end
            default: state_next = ssr_pkg::SSR_WAIT;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg     <= ssr_pkg::SSR_WAIT;
            ctrl_reg      <= `SSR_CTRL_RST;
            rdata_reg     <= 8'h00;
            req_erst_reg  <= 1'b0;
            rst_btn_reg   <= 1'b0;
            ack_btn_reg   <= 1'b0;
            disc_reg      <= 1'b0;
            err_reg       <= 1'b0;
            restored_reg  <= 1'b0;
            blink_reg     <= 1'b0;
            skew_cnt_reg  <= 24'h000000;
            blink_cnt_reg <= 22'h000000;
            warn_cnt_reg  <= 36'h000000000;
        end else begin
            state_reg     <= state_next;
            ctrl_reg      <= ctrl_next;
            rdata_reg     <= rdata_next;
            req_erst_reg  <= req_erst_next;
            rst_btn_reg   <= rst_btn_next;
            ack_btn_reg   <= ack_btn_next;
            disc_reg      <= disc_next;
            err_reg       <= err_next;
            restored_reg  <= restored_next;
            blink_reg     <= blink_next;
            skew_cnt_reg  <= skew_cnt_next;
            blink_cnt_reg <= blink_cnt_next;
            warn_cnt_reg  <= warn_cnt_next;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign safety_output_a = outputs_on; // R18
    assign safety_output_b = outputs_on;
    // Steady when released, blinking while actuated and waiting for release.
    assign yellow_led      = outputs_on | (sense.actuated & blink_reg); // R6
    assign nv_fault_store  = disc_reg; // R12

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    resp_live_a: assert property (reg_re && reg_addr == `SSR_OFF_RESP |=> // R1
        reg_rdata[`SSR_RESP_LIVE_BIT] == $past(both_live))
        else $error("live bit wrong");
    resp_hyst_a: assert property (reg_re && reg_addr == `SSR_OFF_RESP |=> // R2
        reg_rdata[`SSR_RESP_HYST_BIT] == $past(sense.actuated & sense.hysteresis))
        else $error("hysteresis bit wrong");
    warn_comm_a: assert property (reg_re && reg_addr == `SSR_OFF_WARN |=> // R3
        reg_rdata[`SSR_WARN_COMM_BIT] == $past(diag.comm_fail))
        else $error("comm bit wrong");
    err_actr_a: assert property (reg_re && reg_addr == `SSR_OFF_ERR |=> // R4
        reg_rdata[`SSR_ERR_ACTR_BIT] == $past(diag.bad_actuator))
        else $error("actuator bit wrong");
    err_disc_a: assert property (reg_re && reg_addr == `SSR_OFF_ERR |=> // R5
        reg_rdata[`SSR_ERR_DISC_BIT] == $past(disc_reg))
        else $error("discrepancy bit wrong");
    wait_off_a: assert property (state_reg == ssr_pkg::SSR_WAIT |-> // R6
        !safety_output_a && !safety_output_b)
        else $error("outputs on while waiting");
    auto_rel_a: assert property (outputs_on == 1'b0 && release_ok && sense.feedback_closed // R7
        && !ctrl_reg[`SSR_CTRL_BTN_BIT] |=> safety_output_a && yellow_led)
        else $error("auto release missed");
    btn_only_a: assert property (!outputs_on && ctrl_reg[`SSR_CTRL_BTN_BIT] && !rst_fall // R9
        |=> !safety_output_a)
        else $error("release without button edge");
    skew_off_a: assert property (skew && skew_cnt_reg == DISC_CYC |=> // R10
        disc_reg ##1 !safety_output_a)
        else $error("skew did not trip");
    fault_hold_a: assert property (disc_reg && !ack_evt |=> disc_reg) // R11
        else $error("fault lost without acknowledge");
    nv_load_a: assert property (!restored_reg && nv_fault_restore |=> nv_fault_store) // R12
        else $error("stored fault not restored");
    ack_clr_a: assert property (disc_reg && ack_evt && !disc_set && restored_reg // R13
        |=> !disc_reg)
        else $error("acknowledge ignored");
    erst_clr_a: assert property (err_reg && !diag.internal_fault && erst_fall // R17
        |=> !err_reg)
        else $error("error reset ignored");
    on_bit_a: assert property (reg_re && reg_addr == `SSR_OFF_RESP |=> // R18
        reg_rdata[`SSR_RESP_ON_BIT] == $past(safety_output_a))
        else $error("enabled bit wrong");
    warn_off_a: assert property (warn_trip |=> !safety_output_a) // R19
        else $error("warning timeout ignored");
    btn_rel_a: assert property (!outputs_on && release_ok && ctrl_reg[`SSR_CTRL_BTN_BIT] // R8
        && rst_fall |=> safety_output_a && safety_output_b && yellow_led)
        else $error("button release missed");
    nv_block_a: assert property (!restored_reg |=> !safety_output_a && !safety_output_b) // R12
        else $error("release before restored fault");
    open_clr_a: assert property (err_reg && !diag.internal_fault && !sense.actuated // R17
        |=> !err_reg)
        else $error("guard opening did not clear error");

    rel_auto_c: cover property (!outputs_on ##1 outputs_on && !ctrl_reg[`SSR_CTRL_BTN_BIT]);
    rel_btn_c: cover property (!outputs_on ##1 outputs_on && ctrl_reg[`SSR_CTRL_BTN_BIT]);
    disc_ack_c: cover property (disc_reg ##1 !disc_reg);
    warn_trip_c: cover property (warn_trip);
    nv_restore_c: cover property (!restored_reg && nv_fault_restore ##1 disc_reg);
endmodule

// ===== test/ssr_gw_model.sv
// Gateway model: reaches the sensor registers over the plain register port.
// Assumes one clock shared with the sensor logic and calls made from the bench.
`timescale 1ns/1ns
`include "ssr_regs.svh"

module ssr_gw_model (
    input  wire logic                   ref_clk,
    input  wire logic [7:0]             reg_rdata,
    output logic      [`SSR_ADDR_W-1:0] reg_addr,
    output logic      [7:0]             reg_wdata,
    output logic                        reg_we,
    output logic                        reg_re
);
    initial begin
        reg_addr  = 3'h0;
        reg_wdata = 8'h00;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end

    // Idle lines carry the inverse of the last value, so stale data never looks valid.
    task automatic wr(input logic [`SSR_ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge ref_clk);
        reg_we    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [`SSR_ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge ref_clk);
        reg_re   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    task automatic ack_disc();
        wr(`SSR_OFF_REQ, 8'h40);
    endtask

    // The error reset acts on the falling bit, so two writes are needed.
    task automatic err_reset();
        wr(`SSR_OFF_REQ, 8'h80);
        wr(`SSR_OFF_REQ, 8'h00);
    endtask
endmodule

// ===== test/ssr_top_tb_top.sv
// Bench for the sensor release logic: release variants, discrepancy and diagnostic bytes.
// Assumes the gateway model on the register port and shortened count parameters.
`timescale 1ns/1ns
`include "ssr_regs.svh"

module ssr_top_tb_top;
    logic                   ref_clk;
    logic                   sys_rst;
    logic                   nv_fault_restore;
    logic                   nv_fault_store;
    logic                   reg_we;
    logic                   reg_re;
    logic                   safety_output_a;
    logic                   safety_output_b;
    logic                   yellow_led;
    logic [`SSR_ADDR_W-1:0] reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    logic [7:0]             v;
    ssr_pkg::ssr_sense_t    sense;
    ssr_pkg::ssr_diag_t     diag;
    int                     mismatches;
    int                     n_compared;
    int                     cycles;
    logic [7:0]             warn_exp [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};

    ssr_top #(.DISC_CYC(24'd20), .BLINK_CYC(22'd4), .WARN_CYC(36'd30)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sense(sense), .diag(diag),
        .nv_fault_restore(nv_fault_restore), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
        .yellow_led(yellow_led), .nv_fault_store(nv_fault_store));

    ssr_gw_model gw (
        .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re));

    always #20 ref_clk = ~ref_clk;

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The ceiling is about fifteen times the length of all scenarios together.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            print_verdict();
        end
    end

    function automatic logic [7:0] outs();
        return {5'h00, safety_output_a, safety_output_b, yellow_led};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic st(input int n);
        wt(n);
        #1;
    endtask

    task automatic arm(input logic fb);
        wt(1);
        sense.actuated        <= 1'b1;
        sense.safety_input_a  <= 1'b1;
        sense.safety_input_b  <= 1'b1;
        sense.feedback_closed <= fb;
    endtask

    task automatic t_power();
        int   t;
        logic l;
        gw.rd(`SSR_OFF_CTRL, v);
        chk(v, `SSR_CTRL_RST);
        gw.rd(`SSR_OFF_REQ, v);
        chk(v, `SSR_REQ_RST);
        gw.wr(3'h5, 8'hFF);
        gw.rd(3'h5, v);
        chk(v, 8'h00);
        arm(1'b0);
        gw.wr(`SSR_OFF_RESP, 8'hFF);
        st(2);
        t = 0;
        l = yellow_led;
        repeat (40) begin
            st(1);
            if (yellow_led !== l) t++;
            l = yellow_led;
        end
        chk(8'(t inside {[9:10]}), 8'h01);
        chk(outs() & 8'h06, 8'h00);
        gw.rd(`SSR_OFF_RESP, v);
        chk(v, 8'h1A);
        $display("test power done");
    endtask

    task automatic t_release();
        wt(1);
        sense.feedback_closed <= 1'b1;
        st(1);
        chk(outs(), 8'h07);
        wt(1);
        sense.hysteresis <= 1'b1;
        gw.rd(`SSR_OFF_RESP, v);
        chk(v, 8'h33);
        sense.hysteresis <= 1'b0;
        sense.actuated   <= 1'b0;
        st(2);
        chk(outs(), 8'h00);
        gw.wr(`SSR_OFF_CTRL, 8'h02);
        arm(1'b1);
        st(6);
        chk(outs() & 8'h06, 8'h00);
        gw.rd(`SSR_OFF_RESP, v);
        chk(v, 8'h1A);
        sense.reset_button <= 1'b1;
        st(2);
        chk(outs() & 8'h06, 8'h00);
        wt(1);
        sense.reset_button <= 1'b0;
        st(1);
        chk(outs(), 8'h07);
        $display("test release done");
    endtask

    task automatic t_disc();
        gw.wr(`SSR_OFF_CTRL, 8'h01);
        st(2);
        chk(outs(), 8'h07);
        wt(1);
        sense.safety_input_b <= 1'b0;
        st(10);
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h00);
        st(15);
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h40);
        chk(8'(nv_fault_store), 8'h01);
        sense.safety_input_b <= 1'b1;
        st(5);
        chk(outs() & 8'h06, 8'h00);
        wt(1);
        sense.ack_button <= 1'b1;
        wt(1);
        sense.ack_button <= 1'b0;
        st(3);
        chk(outs(), 8'h07);
        wt(1);
        sense.safety_input_a <= 1'b0;
        wt(30);
        sense.safety_input_a <= 1'b1;
        st(3);
        chk(outs() & 8'h06, 8'h00);
        gw.ack_disc();
        st(3);
        chk(outs(), 8'h07);
        chk(8'(nv_fault_store), 8'h00);
        // A second reset with the saved fault restored must come back blocked.
        wt(1);
        nv_fault_restore <= 1'b1;
        sys_rst          <= 1'b1;
        wt(2);
        sys_rst <= 1'b0;
        wt(2);
        nv_fault_restore <= 1'b0;
        st(5);
        chk(outs() & 8'h06, 8'h00);
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h40);
        sense.ack_button <= 1'b1;
        wt(1);
        sense.ack_button <= 1'b0;
        st(3);
        chk(outs(), 8'h07);
        $display("test discrepancy done");
    endtask

    task automatic t_diag();
        for (int i = 0; i < 6; i++) begin
            wt(1);
            diag <= 7'h40 >> i;
            gw.rd(`SSR_OFF_WARN, v);
            chk(v, warn_exp[i]);
            diag <= 7'h00;
        end
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h20);
        gw.rd(`SSR_OFF_RESP, v);
        chk(v, 8'h9A);
        gw.err_reset();
        st(3);
        chk(outs(), 8'h07);
        diag <= 7'h08;
        st(20);
        chk(outs(), 8'h07);
        st(20);
        chk(outs() & 8'h06, 8'h00);
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h08);
        diag <= 7'h01;
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h10);
        diag <= 7'h04;
        st(2);
        diag <= 7'h00;
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h20);
        sense.actuated <= 1'b0;
        st(2);
        gw.rd(`SSR_OFF_ERR, v);
        chk(v, 8'h00);
        $display("test diagnostics done");
    endtask

    initial begin
        ref_clk          = 1'b0;
        sys_rst          = 1'b1;
        sense            = 7'h00;
        diag             = 7'h00;
        nv_fault_restore = 1'b0;
        mismatches       = 0;
        n_compared       = 0;
        cycles           = 0;
        wt(16);
        sys_rst <= 1'b0;
        t_power();
        t_release();
        t_disc();
        t_diag();
        print_verdict();
    end
endmodule
